// ### common/nswap_defines.svh
/*
 * Constants of the nibble-swap execution unit: opcode pattern, field
 * positions, address map figures and reset values.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef NSWAP_DEFINES_SVH
`define NSWAP_DEFINES_SVH

`define NSWAP_ADDR_W        12
`define NSWAP_MEM_DEPTH     4096
`define NSWAP_BANK_W        4
`define NSWAP_STATUS_W      5

`define NSWAP_OPC_MASK      16'hFC00
`define NSWAP_OPC_MATCH     16'h3800
`define NSWAP_TARGET_BIT    9
`define NSWAP_VIEW_BIT      8
`define NSWAP_F_HI          7
`define NSWAP_F_LO          0

`define NSWAP_IDX_LIMIT     8'h5F
`define NSWAP_ACCESS_LOW    12'h000
`define NSWAP_ACCESS_HIGH   12'hF00

`define NSWAP_RST_BYTE      8'h00
`define NSWAP_RST_ADDR      12'h000
`define NSWAP_RST_STATUS    5'h00
`define NSWAP_RST_INSTR     16'h0000

`endif

// ### common/nswap_pkg.sv
/*
 * Types and shared functions of the nibble-swap execution unit.
 * Assumes the constants header is on the include path.
 */
`include "nswap_defines.svh"

package nswap_pkg;

    typedef logic [`NSWAP_ADDR_W-1:0]   addr_t;
    typedef logic [7:0]                 byte_t;
    typedef logic [`NSWAP_BANK_W-1:0]   bank_t;
    typedef logic [`NSWAP_STATUS_W-1:0] status_t;
    typedef logic [15:0]                instr_t;

    // Exchange upper and lower halves of a byte
    function automatic byte_t swap_nibbles(input byte_t v);
        swap_nibbles = {v[3:0], v[7:4]};
    endfunction

endpackage

// ### common/data_mem_if.sv
/*
 * Carrier between the execution unit and its data memory.
 * Assumes one clock; read data are registered inside the memory.
 */
`timescale 1ns/1ps

interface data_mem_if;
    import nswap_pkg::*;

    addr_t addr;
    logic  rd_en;
    logic  wr_en;
    byte_t wr_data;
    byte_t rd_data;

    modport ctrl (output addr, output rd_en, output wr_en, output wr_data, input rd_data);
    modport mem  (input addr, input rd_en, input wr_en, input wr_data, output rd_data);
endinterface

// ### src/data_memory.sv
/*
 * Data memory of general purpose registers, one port, registered read.
 * Assumes the controller never reads and writes in the same cycle.
 */
`timescale 1ns/1ps
`include "nswap_defines.svh"

module data_memory (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Memory port
    data_mem_if.mem  port
);
    import nswap_pkg::*;

    byte_t cells [`NSWAP_MEM_DEPTH];
    byte_t rd_q;

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            cells[port.addr] <= port.wr_data;
        end
        if (reset) begin
            rd_q <= `NSWAP_RST_BYTE;
        end else if (port.rd_en) begin
            rd_q <= cells[port.addr];
        end
    end

    assign port.rd_data = rd_q;
endmodule

// ### src/nibble_swap_unit.sv
/*
 * Execution unit for the nibble-swap instruction of an 8-bit core,
 * with its own data memory, accumulator and status flags.
 * Assumes instruction words arrive from logic on the same clock.
 */
// Behaviour
// - The result byte carries operand bits 3..0 in bits 7..4 and operand bits 7..4 in bits 3..0.
// - With the target bit at 0 the result goes to the accumulator and the operand stays unchanged.
// - With the target bit at 1 the result is written back into the operand register.
// - With the view bit at 0 and no indexed addressing the operand lies in the fixed access bank.
// - With the view bit at 1 the operand address is the bank pointer joined with the 8-bit operand field.
// - With extended mode on, view bit 0 and operand field at most 95 the address is index base plus field.
// - One word, one cycle of four quarters: decode, read operand, process, write destination.
// - The instruction is recognised by the pattern 0011 10da followed by eight operand bits.
`timescale 1ns/1ps
`include "nswap_defines.svh"

module nibble_swap_unit (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // Instruction issue
    input  wire logic                instr_valid,
    input  wire nswap_pkg::instr_t   instr_word,
    input  wire logic                extended_mode,
    input  wire nswap_pkg::bank_t    bank_pointer,
    input  wire nswap_pkg::addr_t    index_base,
    output logic                     busy,
    output logic                     done,
    output logic                     rejected,
    // Core state
    input  wire logic                acc_load,
    input  wire nswap_pkg::byte_t    acc_load_data,
    input  wire logic                status_load,
    input  wire nswap_pkg::status_t  status_load_data,
    output nswap_pkg::byte_t         accumulator,
    output nswap_pkg::status_t       status_flags,
    // Host memory access while idle
    input  wire logic                host_en,
    input  wire logic                host_we,
    input  wire nswap_pkg::addr_t    host_addr,
    input  wire nswap_pkg::byte_t    host_wdata,
    output nswap_pkg::byte_t         host_rdata,
    output logic                     host_rvalid
);
    import nswap_pkg::*;

    typedef enum logic [4:0] {
        IDLE = 5'b00001,
        Q1   = 5'b00010,
        Q2   = 5'b00100,
        Q3   = 5'b01000,
        Q4   = 5'b10000
    } phase_t;

    typedef struct packed {
        phase_t  phase;
        instr_t  instr;
        logic    ext;
        bank_t   bank;
        addr_t   base;
        addr_t   addr;
        byte_t   result;
        byte_t   acc;
        status_t status;
        logic    busy;
        logic    done;
        logic    rejected;
        logic    host_rd;
        byte_t   host_rdata;
        logic    host_rvalid;
    } unit_state_t;

    unit_state_t st;
    unit_state_t next_st;

    data_mem_if mem_bus ();

    data_memory u_mem (
        .clk   (clk),
        .reset (reset),
        .port  (mem_bus.mem)
    );

    function automatic logic is_swap(input instr_t w);
        is_swap = (w & `NSWAP_OPC_MASK) == `NSWAP_OPC_MATCH;
    endfunction

    function automatic byte_t field_f(input instr_t w);
        field_f = w[`NSWAP_F_HI:`NSWAP_F_LO];
    endfunction

    // Operand address from view bit, mode and operand field
    function automatic addr_t operand_addr(input instr_t w, input logic ext, input bank_t bank,
                                           input addr_t base);
        byte_t f;
        f = field_f(w);
        if (w[`NSWAP_VIEW_BIT]) begin
            operand_addr = {bank, f};
        end else if (ext && f <= `NSWAP_IDX_LIMIT) begin
            operand_addr = base + {4'h0, f};
        end else if (f <= `NSWAP_IDX_LIMIT) begin
            operand_addr = `NSWAP_ACCESS_LOW | {4'h0, f};
        end else begin
            operand_addr = `NSWAP_ACCESS_HIGH | {4'h0, f};
        end
    endfunction

    always_comb begin
        next_st             = st;
        next_st.done        = 1'b0;
        next_st.rejected    = 1'b0;
        next_st.host_rvalid = 1'b0;
        next_st.host_rd     = 1'b0;
        mem_bus.addr        = st.addr;
        mem_bus.rd_en       = 1'b0;
        mem_bus.wr_en       = 1'b0;
        mem_bus.wr_data     = st.result;

        if (st.host_rd) begin
            next_st.host_rdata  = mem_bus.rd_data;
            next_st.host_rvalid = 1'b1;
        end

        case (st.phase)
            IDLE: begin
                if (acc_load) begin
                    next_st.acc = acc_load_data;
                end
                if (status_load) begin
                    next_st.status = status_load_data;
                end
                if (instr_valid) begin
                    if (is_swap(instr_word)) begin
                        next_st.instr = instr_word;
                        next_st.ext   = extended_mode;
                        next_st.bank  = bank_pointer;
                        next_st.base  = index_base;
                        next_st.busy  = 1'b1;
                        next_st.phase = Q1;
                    end else begin
                        next_st.rejected = 1'b1;
                    end
                end else if (host_en) begin
                    mem_bus.addr    = host_addr;
                    mem_bus.wr_data = host_wdata;
                    mem_bus.wr_en   = host_we;
                    mem_bus.rd_en   = !host_we;
                    next_st.host_rd = !host_we;
                end
            end
            Q1: begin
                next_st.addr  = operand_addr(st.instr, st.ext, st.bank, st.base);
                next_st.phase = Q2;
            end
            Q2: begin
                mem_bus.rd_en = 1'b1;
                next_st.phase = Q3;
            end
            Q3: begin
                next_st.result = swap_nibbles(mem_bus.rd_data);
                next_st.phase  = Q4;
            end
            Q4: begin
                if (st.instr[`NSWAP_TARGET_BIT]) begin
                    mem_bus.wr_en = 1'b1;
                end else begin
                    next_st.acc = st.result;
                end
                // Status flags are not touched here
                next_st.busy  = 1'b0;
                next_st.done  = 1'b1;
                next_st.phase = IDLE;
            end
            default: begin
                next_st.phase = IDLE;
                next_st.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st.phase       <= IDLE;
            st.instr       <= `NSWAP_RST_INSTR;
            st.ext         <= 1'b0;
            st.bank        <= '0;
            st.base        <= `NSWAP_RST_ADDR;
            st.addr        <= `NSWAP_RST_ADDR;
            st.result      <= `NSWAP_RST_BYTE;
            st.acc         <= `NSWAP_RST_BYTE;
            st.status      <= `NSWAP_RST_STATUS;
            st.busy        <= 1'b0;
            st.done        <= 1'b0;
            st.rejected    <= 1'b0;
            st.host_rd     <= 1'b0;
            st.host_rdata  <= `NSWAP_RST_BYTE;
            st.host_rvalid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign busy         = st.busy;
    assign done         = st.done;
    assign rejected     = st.rejected;
    assign accumulator  = st.acc;
    assign status_flags = st.status;
    assign host_rdata   = st.host_rdata;
    assign host_rvalid  = st.host_rvalid;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence quarters_s;
        st.phase == Q2 ##1 st.phase == Q3 ##1 st.phase == Q4 ##1 (st.phase == IDLE && done);
    endsequence

    a_swap_to_acc: assert property (done && !st.instr[`NSWAP_TARGET_BIT] |->
        accumulator == {$past(mem_bus.rd_data[3:0], 2), $past(mem_bus.rd_data[7:4], 2)})
        else $error("accumulator does not hold swapped operand");

    a_acc_target: assert property (st.phase == Q4 && !st.instr[`NSWAP_TARGET_BIT] |->
        !mem_bus.wr_en ##1 accumulator == $past(st.result))
        else $error("accumulator target wrote memory or missed result");

    a_mem_target: assert property (mem_bus.wr_en && st.phase != IDLE |->
        st.phase == Q4 && st.instr[`NSWAP_TARGET_BIT] && mem_bus.wr_data == st.result
        ##1 $stable(accumulator))
        else $error("write back to operand wrong");

    a_access_addr: assert property (st.phase == Q2 && !st.instr[`NSWAP_VIEW_BIT]
        && !(st.ext && st.instr[7:0] <= `NSWAP_IDX_LIMIT) |->
        mem_bus.addr == ((st.instr[7:0] <= `NSWAP_IDX_LIMIT) ? {4'h0, st.instr[7:0]}
                                                            : {4'hF, st.instr[7:0]}))
        else $error("access bank address wrong");

    a_bank_addr: assert property (st.phase == Q2 && st.instr[`NSWAP_VIEW_BIT] |->
        mem_bus.addr == {st.bank, st.instr[7:0]})
        else $error("banked address wrong");

    a_indexed_addr: assert property (st.phase == Q2 && !st.instr[`NSWAP_VIEW_BIT] && st.ext
        && st.instr[7:0] <= `NSWAP_IDX_LIMIT |-> mem_bus.addr == st.base + {4'h0, st.instr[7:0]})
        else $error("indexed address wrong");

    a_quarter_order: assert property (st.phase == Q1 |=> quarters_s)
        else $error("quarter sequence broken");

    a_decode_match: assert property (st.phase == IDLE && instr_valid |=>
        (st.phase == Q1) == is_swap($past(instr_word)) && rejected != (st.phase == Q1))
        else $error("instruction pattern decode wrong");

    a_status_kept: assert property (busy |=> $stable(status_flags))
        else $error("status changed during swap");
endmodule

// ### verification/test_nibble_swap_unit.sv
/* Self-checking bench of the nibble-swap execution unit.
   Assumes the unit alone, driven from its own ports. */
`timescale 1ns/1ps
`include "nswap_defines.svh"

module test_nibble_swap_unit;
import nswap_pkg::*;

typedef struct packed {byte_t acc; status_t st;} ins_exp_t;

logic     clk = 0, reset = 1, instr_valid = 0, extended_mode = 0;
logic     acc_load = 0, status_load = 0, host_en = 0, host_we = 0;
logic     stray = 0;
instr_t   instr_word = 0;
bank_t    bank_pointer = 0;
addr_t    index_base = 0, host_addr = 0;
byte_t    acc_load_data = 0, host_wdata = 0, acc_m;
status_t  status_load_data = 0, st_m;
logic     busy, done, rejected, host_rvalid;
byte_t    accumulator, host_rdata;
status_t  status_flags;
byte_t    mem_m [4096];
addr_t    touched [$];
ins_exp_t q_ins [$];
ins_exp_t e;
byte_t    q_rd [$];
instr_t   w;
int       n_errors = 0, n_compared = 0, i;

nibble_swap_unit nibble_swap_unit_i (
    .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .extended_mode(extended_mode), .bank_pointer(bank_pointer), .index_base(index_base),
    .busy(busy), .done(done), .rejected(rejected), .acc_load(acc_load),
    .acc_load_data(acc_load_data), .status_load(status_load), .status_load_data(status_load_data),
    .accumulator(accumulator), .status_flags(status_flags), .host_en(host_en), .host_we(host_we),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid)
);

initial begin
    forever #20 clk = ~clk;
end

task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
        n_errors++;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
endtask

task end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask

// Effective operand address
function automatic addr_t eff(instr_t iw, logic ext, bank_t bp, addr_t base);
    if (iw[8])
        return {bp, iw[7:0]};
    if (ext && iw[7:0] <= 8'h5F)
        return base + {4'h0, iw[7:0]};
    return (iw[7:0] <= 8'h5F) ? {4'h0, iw[7:0]} : {4'hF, iw[7:0]};
endfunction

task host(input logic we, input addr_t a, input byte_t d);
    @(posedge clk);
    host_en <= 1;
    host_we <= we;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_en <= 0;
    if (we)
        mem_m[a] = d;
    else begin
        q_rd.push_back(mem_m[a]);
        repeat (3) @(posedge clk);
    end
endtask

// Issue one word; a stray host write rides along and must be ignored
task issue(input instr_t iw, input logic ext, input bank_t bp, input addr_t base);
    addr_t a;
    byte_t r;
    int    n;
    logic  sw;
    sw = (iw & `NSWAP_OPC_MASK) == `NSWAP_OPC_MATCH;
    a = eff(iw, ext, bp, base);
    r = {mem_m[a][3:0], mem_m[a][7:4]};
    if (sw) begin
        if (iw[9])
            mem_m[a] = r;
        else
            acc_m = r;
    end
    touched.push_back(a);
    q_ins.push_back('{acc_m, st_m});
    @(posedge clk);
    instr_valid <= 1;
    instr_word <= iw;
    extended_mode <= ext;
    bank_pointer <= bp;
    index_base <= base;
    host_en <= 1;
    host_we <= 1;
    host_addr <= a;
    host_wdata <= ~r;
    @(posedge clk);
    // Optionally keep offering a word and core loads while busy; all must be ignored
    instr_valid <= stray && sw;
    instr_word <= iw ^ 16'h0100;
    acc_load <= stray && sw;
    acc_load_data <= ~acc_m;
    status_load <= stray && sw;
    status_load_data <= ~st_m;
    host_en <= 0;
    for (n = 1; n <= 10; n++) begin
        @(negedge clk);
        if (n == 1) check(16'(busy), 16'(sw));
        if (done === 1'b1 || rejected === 1'b1) break;
        if (n == 4 && stray && sw) begin
            @(posedge clk);
            instr_valid <= 0;
            acc_load <= 0;
            status_load <= 0;
        end
    end
    if (n > 10) begin
        n_errors++;
        $display("BAD %0t no completion", $time);
        end_sim();
    end
    check(16'(n), sw ? 16'd5 : 16'd1);
    check(16'(done), 16'(sw));
    check(16'(busy), 16'h0000);
endtask

// Results are matched against the oldest note
always @(negedge clk) begin
    if (!reset && (done === 1'b1 || rejected === 1'b1)) begin
        if (q_ins.size() == 0) begin
            n_errors++;
            $display("BAD %0t unexpected completion", $time);
        end else begin
            e = q_ins.pop_front();
            check(16'(accumulator), 16'(e.acc));
            check(16'(status_flags), 16'(e.st));
        end
    end
    if (!reset && host_rvalid === 1'b1) begin
        if (q_rd.size() == 0) begin
            n_errors++;
            $display("BAD %0t unexpected read data", $time);
        end else
            check(16'(host_rdata), 16'(q_rd.pop_front()));
    end
end

initial begin
    void'($urandom(32'h74d2));
    repeat (20) @(posedge clk);
    reset <= 0;
    @(negedge clk);
    check(16'({busy, done, rejected, host_rvalid, accumulator}), 16'h0000);
    check(16'(status_flags), 16'h0000);
    $display("test reset done");
    for (i = 0; i < 4096; i++)
        host(1, i[11:0], 8'($urandom));
    acc_m = 8'($urandom);
    st_m = 5'($urandom);
    @(posedge clk);
    acc_load <= 1;
    acc_load_data <= acc_m;
    status_load <= 1;
    status_load_data <= st_m;
    @(posedge clk);
    acc_load <= 0;
    status_load <= 0;
    issue(16'h3B3C, 0, 4'hA, 12'h000);
    issue(16'h3980, 1, 4'h5, 12'h000);
    issue(16'h3A5F, 0, 4'h3, 12'h123);
    issue(16'h3860, 0, 4'h3, 12'h123);
    issue(16'h3A5F, 1, 4'h3, 12'h123);
    issue(16'h3A60, 1, 4'h3, 12'h123);
    issue(16'h3820, 1, 4'h3, 12'hFF0);
    $display("test directed done");
    issue(16'h3C00, 0, 4'h0, 12'h000);
    for (i = 0; i < 6; i++) begin
        w = 16'($urandom);
        if ((w & `NSWAP_OPC_MASK) == `NSWAP_OPC_MATCH)
            w = w ^ 16'h0400;
        issue(w, 1'($urandom), 4'($urandom), 12'($urandom));
    end
    $display("test refused words done");
    for (i = 0; i < 40; i++) begin
        stray = i[0];
        issue({6'b001110, 10'($urandom)}, 1'($urandom), 4'($urandom), 12'($urandom));
    end
    stray = 0;
    $display("test random swaps done");
    foreach (touched[j])
        host(0, touched[j], 8'h00);
    check(16'(q_ins.size() + q_rd.size()), 16'h0000);
    $display("test read back done");
    end_sim();
end

endmodule
